// file: idw_builder.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Word 0 reports fixed, non-removable ATA device; bit 6 set.
// - Words 10-19 hold twenty-character serial number, right-justified.
// - Words 23-26 hold eight-character firmware revision, left-justified.
// - Words 27-46 hold forty-character model, left-justified, space padded.
// - Word 49 sets flow control, LBA and DMA; bits 13, 10 zero.
// - Word 51 high byte is 4, meaning PIO mode 4.
// - Word 53 flags words 88, 64-70 and 54-58 valid.
// - Word 59 shows multiple enable and 2/4/8/16 sector count.
// - Fixed 3FFF cylinders, 16 heads; words 60-61 give variant capacity.
// - Word 63 high byte current multiword DMA mode; modes 0-2 supported.
// - Word 64 flags advanced PIO modes 3 and 4.
// - Word 80 flags interface revisions 1 through 4.
// - Word 82 sets bits 13,12,10,6,5,3,1,0 only.
// - Word 83 sets only advanced power management support bit 3.
// - Word 85 reflects look-ahead, write cache, security, monitoring enables.
// - Word 86 bit 3 reflects advanced power management enabled.
// - Word 88 high field current ultra DMA mode; modes 0-4 supported.
// - Word 93 bits 12-0 change only during hardware reset.
// - Word 93 bit 15 zero, bit 14 one, bit 13 cable level.
// - Device 1 sets bit 8, diag bit 11, method 10-9; device 0 clears.
// - Device 0 sets bit 0 and bits 6-1; device 1 clears low byte.
// - Method fields: 01 jumper, 10 cable select, 11 other.
module idw_builder #(
  parameter int SER_CHARS = 20,
  parameter int FW_CHARS = 8,
  parameter int MDL_CHARS = 40,
  parameter logic [31:0] LBA_SECTORS = idw_pkg::V_LBA_DEF
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clkEn,
  // Word request
  input wire logic rdReq,
  input wire logic [7:0] wordIdx,
  output logic rdValid,
  output logic [15:0] rdData,
  // Text fields, first character in the top byte
  input wire logic [SER_CHARS*8-1:0] serialText,
  input wire logic [FW_CHARS*8-1:0] fwText,
  input wire logic [MDL_CHARS*8-1:0] modelText,
  // Current settings
  input wire idw_pkg::idw_mode_t modes,
  input wire idw_pkg::idw_feat_t feats,
  // Hardware reset sensing
  input wire logic hwResetActive,
  input wire idw_pkg::idw_hwres_t hwSample
);
  import idw_pkg::*;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } idw_state_t;
  idw_state_t st_reg, st_next;

  idw_hwres_t held;
  logic [15:0] serWord, fwWord, mdlWord;
  logic [15:0] rstWord;
  logic [SER_CHARS*8-1:0] serRight;
  logic [MDL_CHARS*8-1:0] mdlPadded;

  // Right-justify serial: leading NUL characters become spaces
  always_comb begin
    logic lead;
    lead = 1'b1;
    serRight = serialText;
    for (int c = SER_CHARS - 1; c >= 0; c--) begin
      if (lead && serialText[c*8 +: 8] == 8'h00) begin
        serRight[c*8 +: 8] = ASCII_SPACE;
      end else begin
        lead = 1'b0;
      end
    end
  end

  // Model padding: NUL positions become spaces
  always_comb begin
    mdlPadded = modelText;
    for (int c = 0; c < MDL_CHARS; c++) begin
      if (modelText[c*8 +: 8] == 8'h00) begin
        mdlPadded[c*8 +: 8] = ASCII_SPACE;
      end
    end
  end

  idw_text_rom #(.CHARS(SER_CHARS)) u_ser (
    .text(serRight),
    .offset(8'(wordIdx - W_SER_LO)),
    .word(serWord)
  );
  idw_text_rom #(.CHARS(FW_CHARS)) u_fw (
    .text(fwText),
    .offset(8'(wordIdx - W_FW_LO)),
    .word(fwWord)
  );
  idw_text_rom #(.CHARS(MDL_CHARS)) u_mdl (
    .text(mdlPadded),
    .offset(8'(wordIdx - W_MDL_LO)),
    .word(mdlWord)
  );

  idw_hwres_latch u_hwres (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .clkEn(clkEn),
    .hwResetActive(hwResetActive),
    .sample(hwSample),
    .held(held)
  );

  // Word 93 assembly; reserved method code is shown as unknown
  always_comb begin
    logic [1:0] meth;
    meth = (held.method == METH_RSVD) ? METH_OTHER : held.method;
    rstWord = 16'h4000;
    rstWord[13] = held.cableHigh;
    if (held.isDev1) begin
      rstWord[11] = held.dev1Diag;
      rstWord[10:9] = meth;
      rstWord[8] = 1'b1;
    end else begin
      rstWord[6] = held.respForDev1;
      rstWord[5] = held.sawActive;
      rstWord[4] = held.sawDiag;
      rstWord[3] = held.diagPass;
      rstWord[2:1] = meth;
      rstWord[0] = 1'b1;
    end
  end

  always_comb begin
    logic [15:0] w;
    w = 16'h0000;
    if (wordIdx >= W_SER_LO && wordIdx <= W_SER_HI) begin
      w = serWord;
    end else if (wordIdx >= W_FW_LO && wordIdx <= W_FW_HI) begin
      w = fwWord;
    end else if (wordIdx >= W_MDL_LO && wordIdx <= W_MDL_HI) begin
      w = mdlWord;
    end else begin
      case (wordIdx)
        W_CONFIG: w = V_CONFIG;
        W_CYLS: w = V_CYLS;
        W_HEADS: w = V_HEADS;
        W_SECTRK: w = V_SECTRK;
        W_BUFSZ: w = V_BUFSZ;
        W_ECCB: w = V_ECCB;
        W_MAXMUL: w = V_MAXMUL;
        W_CAPS: w = V_CAPS;
        W_PIO: w = V_PIO;
        W_VALID: w = V_VALID;
        W_MULT: begin
          w[MULT_EN_BIT] = modes.multEn;
          w[7:0] = modes.multCount;
        end
        W_LBA_LO: w = LBA_SECTORS[15:0];
        W_LBA_HI: w = LBA_SECTORS[31:16];
        W_MDMA: w = {modes.mdmaMode, V_MDMA_SUP};
        W_APIO: w = V_APIO;
        W_MAJOR: w = V_MAJOR;
        W_SUP1: w = V_SUP1;
        W_SUP2: w = V_SUP2;
        W_ENA1: begin
          w[ENA_LOOK_BIT] = feats.lookAhead;
          w[ENA_WC_BIT] = feats.writeCache;
          w[ENA_SEC_BIT] = feats.security;
          w[ENA_SMART_BIT] = feats.smart;
        end
        W_ENA2: w[ENA_APM_BIT] = feats.apm;
        W_UDMA: w = {3'h0, modes.udmaMode, 3'h0, V_UDMA_SUP};
        W_RSTRES: w = rstWord;
        default: w = 16'h0000;
      endcase
    end
    st_next = st_reg;
    st_next.valid = rdReq;
    if (rdReq) begin
      st_next.data = w;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else if (clkEn) begin
      st_reg <= st_next;
    end
  end

  assign rdValid = st_reg.valid;
  assign rdData = st_reg.data;

  property p_word0;
    @(posedge core_clk) disable iff (!rst_b)
      (clkEn && rdReq && wordIdx == W_CONFIG) |=> rdData == V_CONFIG;
  endproperty
  a_word0: assert property (p_word0)
    else $error("word 0 mismatch");

  property p_caps;
    @(posedge core_clk) disable iff (!rst_b)
      (clkEn && rdReq && wordIdx == W_CAPS) |=>
        rdData[11] && rdData[9] && rdData[8] && !rdData[13] && !rdData[10];
  endproperty
  a_caps: assert property (p_caps)
    else $error("word 49 capability bits wrong");

  property p_mult;
    @(posedge core_clk) disable iff (!rst_b)
      (clkEn && rdReq && wordIdx == W_MULT) |=>
        rdData == {7'h0, $past(modes.multEn), $past(modes.multCount)};
  endproperty
  a_mult: assert property (p_mult)
    else $error("word 59 does not follow multiple setting");

  property p_cyl_heads;
    @(posedge core_clk) disable iff (!rst_b)
      (clkEn && rdReq && (wordIdx == W_CYLS || wordIdx == W_HEADS)) |=>
        rdData == (($past(wordIdx) == W_CYLS) ? V_CYLS : V_HEADS);
  endproperty
  a_cyl_heads: assert property (p_cyl_heads)
    else $error("geometry word wrong");

  property p_mdma;
    @(posedge core_clk) disable iff (!rst_b)
      (clkEn && rdReq && wordIdx == W_MDMA) |=>
        rdData == {$past(modes.mdmaMode), V_MDMA_SUP};
  endproperty
  a_mdma: assert property (p_mdma)
    else $error("word 63 mismatch");

  property p_sup1;
    @(posedge core_clk) disable iff (!rst_b)
      (clkEn && rdReq && wordIdx == W_SUP1) |=> rdData == V_SUP1;
  endproperty
  a_sup1: assert property (p_sup1)
    else $error("word 82 mismatch");

  property p_apm;
    @(posedge core_clk) disable iff (!rst_b)
      (clkEn && rdReq && wordIdx == W_ENA2) |=>
        rdData == {12'h0, $past(feats.apm), 3'h0};
  endproperty
  a_apm: assert property (p_apm)
    else $error("word 86 mismatch");

  property p_rst_word;
    @(posedge core_clk) disable iff (!rst_b)
      (clkEn && rdReq && wordIdx == W_RSTRES) |=>
        rdData[15:14] == 2'h1 && (rdData[8] ^ rdData[0]) &&
        (rdData[8] ? rdData[7:0] == 8'h00 : rdData[12:8] == 5'h00);
  endproperty
  a_rst_word: assert property (p_rst_word)
    else $error("word 93 fixed bits or device split wrong");

  property p_undef_zero;
    @(posedge core_clk) disable iff (!rst_b)
      (clkEn && rdReq && wordIdx > W_RSTRES) |=> rdData == 16'h0000;
  endproperty
  a_undef_zero: assert property (p_undef_zero)
    else $error("undefined word not zero");

  property p_valid_follows;
    @(posedge core_clk) disable iff (!rst_b)
      clkEn |=> rdValid == $past(rdReq);
  endproperty
  a_valid_follows: assert property (p_valid_follows)
    else $error("read answer timing wrong");

  property p_pio;
    @(posedge core_clk) disable iff (!rst_b)
      (clkEn && rdReq && wordIdx == W_PIO) |=> rdData == V_PIO;
  endproperty
  a_pio: assert property (p_pio)
    else $error("word 51 mismatch");

  property p_ena1;
    @(posedge core_clk) disable iff (!rst_b)
      (clkEn && rdReq && wordIdx == W_ENA1) |=>
        rdData == {9'h000, $past(feats.lookAhead), $past(feats.writeCache),
          3'h0, $past(feats.security), $past(feats.smart)};
  endproperty
  a_ena1: assert property (p_ena1)
    else $error("word 85 does not follow feature enables");

  property p_udma;
    @(posedge core_clk) disable iff (!rst_b)
      (clkEn && rdReq && wordIdx == W_UDMA) |=>
        rdData == {3'h0, $past(modes.udmaMode), 3'h0, V_UDMA_SUP};
  endproperty
  a_udma: assert property (p_udma)
    else $error("word 88 mismatch");

  c_read_serial: cover property (@(posedge core_clk) disable iff (!rst_b)
    clkEn && rdReq && wordIdx == W_SER_LO);
  c_read_rst: cover property (@(posedge core_clk) disable iff (!rst_b)
    clkEn && rdReq && wordIdx == W_RSTRES);
  c_hw_reset: cover property (@(posedge core_clk) disable iff (!rst_b)
    clkEn && hwResetActive ##1 !hwResetActive);
  c_read_dev1: cover property (@(posedge core_clk) disable iff (!rst_b)
    clkEn && rdReq && wordIdx == W_RSTRES && held.isDev1);
  c_frozen: cover property (@(posedge core_clk) disable iff (!rst_b)
    !clkEn && hwResetActive);
endmodule
`default_nettype wire

// file: idw_pkg.sv
package idw_pkg;
  localparam int WORD_W = 16;
  localparam int IDX_W = 8;
  // Word indices
  localparam logic [7:0] W_CONFIG = 8'h00;
  localparam logic [7:0] W_CYLS = 8'h01;
  localparam logic [7:0] W_HEADS = 8'h03;
  localparam logic [7:0] W_SECTRK = 8'h06;
  localparam logic [7:0] W_SER_LO = 8'h0a;
  localparam logic [7:0] W_SER_HI = 8'h13;
  localparam logic [7:0] W_BUFSZ = 8'h15;
  localparam logic [7:0] W_ECCB = 8'h16;
  localparam logic [7:0] W_FW_LO = 8'h17;
  localparam logic [7:0] W_FW_HI = 8'h1a;
  localparam logic [7:0] W_MDL_LO = 8'h1b;
  localparam logic [7:0] W_MDL_HI = 8'h2e;
  localparam logic [7:0] W_MAXMUL = 8'h2f;
  localparam logic [7:0] W_CAPS = 8'h31;
  localparam logic [7:0] W_PIO = 8'h33;
  localparam logic [7:0] W_VALID = 8'h35;
  localparam logic [7:0] W_MULT = 8'h3b;
  localparam logic [7:0] W_LBA_LO = 8'h3c;
  localparam logic [7:0] W_LBA_HI = 8'h3d;
  localparam logic [7:0] W_MDMA = 8'h3f;
  localparam logic [7:0] W_APIO = 8'h40;
  localparam logic [7:0] W_MAJOR = 8'h50;
  localparam logic [7:0] W_SUP1 = 8'h52;
  localparam logic [7:0] W_SUP2 = 8'h53;
  localparam logic [7:0] W_ENA1 = 8'h55;
  localparam logic [7:0] W_ENA2 = 8'h56;
  localparam logic [7:0] W_UDMA = 8'h58;
  localparam logic [7:0] W_RSTRES = 8'h5d;
  // Fixed word values
  localparam logic [15:0] V_CONFIG = 16'h0040;
  localparam logic [15:0] V_CYLS = 16'h3fff;
  localparam logic [15:0] V_HEADS = 16'h0010;
  localparam logic [15:0] V_SECTRK = 16'h003f;
  localparam logic [15:0] V_BUFSZ = 16'h0400;
  localparam logic [15:0] V_ECCB = 16'h0004;
  localparam logic [15:0] V_MAXMUL = 16'h8010;
  localparam logic [15:0] V_CAPS = 16'h0b00;
  localparam logic [15:0] V_PIO = 16'h0400;
  localparam logic [15:0] V_VALID = 16'h0007;
  localparam logic [7:0] V_MDMA_SUP = 8'h07;
  localparam logic [15:0] V_APIO = 16'h0003;
  localparam logic [15:0] V_MAJOR = 16'h001e;
  localparam logic [15:0] V_SUP1 = 16'h346b;
  localparam logic [15:0] V_SUP2 = 16'h0008;
  localparam logic [4:0] V_UDMA_SUP = 5'h1f;
  localparam logic [7:0] ASCII_SPACE = 8'h20;
  localparam logic [31:0] V_LBA_DEF = 32'h01316af0;
  // Word 59 / 85 / 86 bit positions
  localparam int MULT_EN_BIT = 8;
  localparam int ENA_LOOK_BIT = 6;
  localparam int ENA_WC_BIT = 5;
  localparam int ENA_SEC_BIT = 1;
  localparam int ENA_SMART_BIT = 0;
  localparam int ENA_APM_BIT = 3;
  // Device-number method field encodings
  localparam logic [1:0] METH_RSVD = 2'h0;
  localparam logic [1:0] METH_JUMPER = 2'h1;
  localparam logic [1:0] METH_CSEL = 2'h2;
  localparam logic [1:0] METH_OTHER = 2'h3;

  typedef struct packed {
    logic lookAhead;
    logic writeCache;
    logic security;
    logic smart;
    logic apm;
  } idw_feat_t;

  typedef struct packed {
    logic multEn;
    logic [7:0] multCount;
    logic [7:0] mdmaMode;
    logic [4:0] udmaMode;
  } idw_mode_t;

  // Levels sampled while hardware reset runs
  typedef struct packed {
    logic cableHigh;
    logic isDev1;
    logic [1:0] method;
    logic dev1Diag;
    logic respForDev1;
    logic sawActive;
    logic sawDiag;
    logic diagPass;
  } idw_hwres_t;
endpackage

// file: idw_text_rom.sv
`timescale 1ns/1ps
`default_nettype none
// Selects one 16-bit word from a packed character field, first char high
module idw_text_rom #(
  parameter int CHARS = 20
) (
  // Field
  input wire logic [CHARS*8-1:0] text,
  input wire logic [7:0] offset,
  // Word
  output logic [15:0] word
);
  import idw_pkg::*;
  localparam int WORDS = CHARS / 2;
  logic [15:0] words [WORDS];

  genvar i;
  generate
    for (i = 0; i < WORDS; i++) begin : g_w
      assign words[i] = text[CHARS*8-1-16*i -: 16];
    end
  endgenerate

  always_comb begin
    word = 16'h0000;
    if (32'(offset) < WORDS) begin
      word = words[offset[$clog2(WORDS)-1:0]];
    end
  end
endmodule
`default_nettype wire

// file: idw_hwres_latch.sv
`timescale 1ns/1ps
`default_nettype none
// Captures word 93 inputs only while hardware reset is executing
module idw_hwres_latch (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clkEn,
  // Capture
  input wire logic hwResetActive,
  input wire idw_pkg::idw_hwres_t sample,
  // Result
  output idw_pkg::idw_hwres_t held
);
  import idw_pkg::*;
  typedef struct packed {
    idw_hwres_t res;
  } idw_latch_state_t;
  idw_latch_state_t st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    if (hwResetActive) begin
      st_next.res = sample;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else if (clkEn) begin
      st_reg <= st_next;
    end
  end

  assign held = st_reg.res;

  property p_hold_outside_reset;
    @(posedge core_clk) disable iff (!rst_b)
      (clkEn && !hwResetActive) |=> $stable(held);
  endproperty
  a_hold_outside_reset: assert property (p_hold_outside_reset)
    else $error("word 93 capture changed outside hardware reset");
endmodule
`default_nettype wire

// file: idw_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host side of the word port: sweeps all indices back to back
module idw_host_model (
  // Clock
  input wire logic core_clk,
  // Word port
  output logic rdReq,
  output logic [7:0] wordIdx,
  input wire logic rdValid,
  input wire logic [15:0] rdData
);
  import idw_pkg::*;

  logic [15:0] got [256];
  int nGot;

  initial begin
    rdReq = 1'b0;
    wordIdx = 8'h00;
  end

  // One request per edge; each answer is sampled two edges later
  task automatic sweep();
    int i;
    nGot = 0;
    for (i = 0; i < 258; i++) begin
      @(posedge core_clk);
      if (rdValid === 1'b1 && nGot < 256) begin
        got[nGot] = rdData;
        nGot++;
      end
      rdReq <= (i < 256);
      // Idle index flips so a stale index never looks live
      wordIdx <= (i < 256) ? i[7:0] : ~wordIdx;
    end
  endtask
endmodule
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin numChecks++; if ((g) !== (e)) begin nFail++; \
  $display("unexpected at %0t: got %h exp %h", $time, (g), (e)); end end
module tb_top;
  import idw_pkg::*;

  localparam logic [31:0] LBA = 32'h01ca1e70;
  logic core_clk, rst_b, clkEn, rdReq, rdValid, hwResetActive;
  logic [7:0] wordIdx;
  logic [15:0] rdData;
  logic [159:0] serialText;
  logic [63:0] fwText;
  logic [319:0] modelText;
  idw_mode_t modes;
  idw_feat_t feats;
  idw_hwres_t hwSample, heldExp;
  int nFail, numChecks;
  int cycles = 0;

  idw_builder #(.LBA_SECTORS(LBA)) i_dut (
    .core_clk(core_clk), .rst_b(rst_b), .clkEn(clkEn),
    .rdReq(rdReq), .wordIdx(wordIdx), .rdValid(rdValid), .rdData(rdData),
    .serialText(serialText), .fwText(fwText), .modelText(modelText),
    .modes(modes), .feats(feats),
    .hwResetActive(hwResetActive), .hwSample(hwSample)
  );

  idw_host_model i_host (
    .core_clk(core_clk), .rdReq(rdReq), .wordIdx(wordIdx),
    .rdValid(rdValid), .rdData(rdData)
  );

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic printVerdict();
    $display("checks %0d, mismatches %0d", numChecks, nFail);
    if (nFail == 0 && numChecks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Cycle count for the run ceiling
  always @(posedge core_clk) begin
    cycles++;
  end

  function automatic logic [7:0] chr(input logic [319:0] f, input int n,
      input int len, input logic pad);
    logic [7:0] c;
    c = f[(len-1-n)*8 +: 8];
    return (pad && c == 8'h00) ? ASCII_SPACE : c;
  endfunction

  function automatic logic [15:0] txtW(input logic [319:0] f, input int len,
      input int w, input logic pad);
    return {chr(f, 2*w, len, pad), chr(f, 2*w+1, len, pad)};
  endfunction

  // Reserved method code is reported as unknown
  function automatic logic [15:0] w93(input idw_hwres_t s);
    logic [1:0] m;
    m = (s.method == METH_RSVD) ? METH_OTHER : s.method;
    if (s.isDev1) return {2'h1, s.cableHigh, 1'b0, s.dev1Diag, m, 1'b1, 8'h00};
    return {2'h1, s.cableHigh, 5'h00, 1'b0, s.respForDev1, s.sawActive,
      s.sawDiag, s.diagPass, m, 1'b1};
  endfunction

  task automatic checkAll();
    int i;
    i_host.sweep();
    `CHK(i_host.nGot, 256)
    for (i = 0; i < 256; i++)
      if (i inside {2, [4:5], [7:9], 20, 48, 50, 52, 62, [69:79], 90, 92,
          [94:127], [129:255]})
        `CHK(i_host.got[i], 16'h0000)
    `CHK(i_host.got[0], 16'h0040)
    for (i = 0; i < 10; i++)
      `CHK(i_host.got[10+i], txtW(320'(serialText), 20, i, 1'b1))
    for (i = 0; i < 4; i++)
      `CHK(i_host.got[23+i], txtW(320'(fwText), 8, i, 1'b0))
    for (i = 0; i < 20; i++)
      `CHK(i_host.got[27+i], txtW(modelText, 40, i, 1'b1))
    `CHK(i_host.got[49], 16'h0b00)
    `CHK(i_host.got[51], 16'h0400)
    `CHK(i_host.got[53], 16'h0007)
    `CHK(i_host.got[59], {7'h00, modes.multEn, modes.multCount})
    `CHK(i_host.got[1], 16'h3fff)
    `CHK(i_host.got[3], 16'h0010)
    `CHK({i_host.got[61], i_host.got[60]}, LBA)
    `CHK(i_host.got[63], {modes.mdmaMode, 8'h07})
    `CHK(i_host.got[64], 16'h0003)
    `CHK(i_host.got[80], 16'h001e)
    `CHK(i_host.got[82], 16'h346b)
    `CHK(i_host.got[83], 16'h0008)
    `CHK(i_host.got[85], {9'h000, feats.lookAhead, feats.writeCache, 3'h0,
      feats.security, feats.smart})
    `CHK(i_host.got[86], {12'h000, feats.apm, 3'h0})
    `CHK(i_host.got[88], {3'h0, modes.udmaMode, 8'h1f})
    `CHK(i_host.got[93], w93(heldExp))
  endtask

  initial begin
    idw_hwres_t s;
    int m;
    rst_b = 1'b0;
    clkEn = 1'b1;
    hwResetActive = 1'b0;
    hwSample = '0;
    heldExp = '0;
    modes = '0;
    feats = '0;
    nFail = 0;
    numChecks = 0;
    // Leading zero bytes stand for right-justify padding
    serialText = {32'h0, "SN0123456789ABCD"};
    fwText = "FW1.23 B";
    modelText = {"MODEL DISK 10G", 208'h0};
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    fork
      begin
        checkAll();
        // Both devices, every method code, varied modes and enables
        for (m = 0; m < 8; m++) begin
          s = {m[0], m[2], m[1:0], m[1], m[0], ~m[0], m[2], m[1]};
          @(posedge core_clk);
          modes <= {m[0], 8'(2 << m[1:0]), 8'(m % 3), 5'(m % 5)};
          feats <= 5'(m * 7);
          hwSample <= s;
          hwResetActive <= 1'b1;
          repeat (2) @(posedge core_clk);
          hwResetActive <= 1'b0;
          // Changes outside hardware reset must not reach word 93
          hwSample <= ~s;
          heldExp = s;
          checkAll();
        end
        // Capture frozen while clock enable is low; inverse sample
        // flips the device split, so a leak shows in word 93
        @(posedge core_clk);
        clkEn <= 1'b0;
        hwResetActive <= 1'b1;
        hwSample <= ~heldExp;
        repeat (3) @(posedge core_clk);
        clkEn <= 1'b1;
        hwResetActive <= 1'b0;
        checkAll();
      end
      // Run is about 2600 cycles; the ceiling leaves wide margin
      begin
        wait (cycles >= 20000);
        nFail++;
        $display("unexpected at %0t: timeout", $time);
      end
    join_any
    printVerdict();
  end
endmodule
`default_nettype wire
